// ### irp_map.svh
// constants of the i2c register read port: offsets, fields, reset values
`ifndef IRP_MAP_SVH
`define IRP_MAP_SVH
`define IRP_ADDR_BASE 7'h38
`define IRP_OP_READ 3'h4
`define IRP_OP_MSB 2
`define IRP_PORT_HI_BIT 0
`define IRP_PORT_LO_BIT 7
`define IRP_BE_MSB 5
`define IRP_BE_LSB 2
`define IRP_AHI_MSB 1
`define IRP_NUM_CMD 3'h4
`define IRP_LAST_CMD 3'h3
`define IRP_BITS 4'h8
`define IRP_LAST_BIT 4'h7
`define IRP_BUF_RST 32'h0000_0000
`define IRP_REQ_W 16
`endif

// ### irp_pkg.sv
// types of the i2c register read port
package irp_pkg;
  // link-side protocol states
  typedef enum logic [3:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_CMD, LK_CMD_ACK,
    LK_STRETCH, LK_RD_BYTE, LK_RD_ACK, LK_RD_NEXT, LK_WAIT
  } irp_link_st_t;
  // core-side register access states
  typedef enum logic [1:0] {
    CR_IDLE, CR_WAIT_ACK, CR_RETURN
  } irp_core_st_t;
  // all link-domain state
  typedef struct packed {
    logic ce_s1;
    logic ce_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    irp_link_st_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic [2:0] cmd_idx;
    logic [3:0][7:0] cmd;
    logic [31:0] hold;
    logic [1:0] byte_sel;
    logic pend;
    logic sda_oe;
    logic scl_oe;
    logic req_go;
  } irp_link_t;
  // all core-domain state
  typedef struct packed {
    irp_core_st_t state;
    logic [1:0] port;
    logic [9:0] addr;
    logic [3:0] be;
    logic [31:0] data;
    logic req;
    logic ret_go;
  } irp_core_t;
endpackage

// ### irp_xfer_if.sv
// word crossing between two clock domains: sender and receiver signals
`timescale 1ns/1ns
interface irp_xfer_if #(parameter int W = 16);
  logic src_valid;
  logic [W-1:0] src_data;
  logic src_busy;
  logic dst_valid;
  logic [W-1:0] dst_data;
  // the crossing logic itself
  modport xfer(input src_valid, input src_data, output src_busy,
               output dst_valid, output dst_data);
  // the logic that sends on one side and receives on the other
  modport user(output src_valid, output src_data, input src_busy,
               input dst_valid, input dst_data);
endinterface

// ### irp_xfer.sv
// toggle handshake that carries one word between two clock domains
`timescale 1ns/1ns
module irp_xfer #(
  parameter int W = 16
) (
  input wire logic src_clk,
  input wire logic src_rstn,
  input wire logic src_ce,
  input wire logic dst_clk,
  input wire logic dst_rstn,
  input wire logic dst_ce,
  irp_xfer_if.xfer x
);
  // sender side state
  typedef struct packed {
    logic tog;
    logic [W-1:0] data;
    logic ack_s1;
    logic ack_s2;
  } irp_xs_t;
  // receiver side state
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic seen;
    logic valid;
    logic [W-1:0] data;
  } irp_xd_t;

  irp_xs_t s_reg;
  irp_xs_t s_next;
  irp_xd_t d_reg;
  irp_xd_t d_next;

  // elaboration check: a zero-width word cannot be carried
  if (W < 1) begin : g_bad_w
    $error("irp_xfer: width must be positive");
  end

  // -------------------------------------------------------------
  // sender: flips the toggle and holds the word until acknowledged
  // -------------------------------------------------------------
  assign x.src_busy = s_reg.tog ^ s_reg.ack_s2;

  // data stays frozen while busy, so the receiver may read it freely
  always_comb begin
    s_next = s_reg;
    if (src_ce) begin
      s_next.ack_s1 = d_reg.seen;
      s_next.ack_s2 = s_reg.ack_s1;
      if (x.src_valid && !x.src_busy) begin
        s_next.tog = ~s_reg.tog;
        s_next.data = x.src_data;
      end
    end
  end

  // sender registers
  always_ff @(posedge src_clk or negedge src_rstn) begin
    if (!src_rstn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------
  // receiver: a toggle change means a new word is waiting
  // -------------------------------------------------------------
  assign x.dst_valid = d_reg.valid;
  assign x.dst_data = d_reg.data;

  // one-cycle valid pulse per word, data captured into a register
  always_comb begin
    d_next = d_reg;
    d_next.valid = 1'b0;
    if (dst_ce) begin
      d_next.req_s1 = s_reg.tog;
      d_next.req_s2 = d_reg.req_s1;
      if (d_reg.req_s2 != d_reg.seen) begin
        d_next.seen = d_reg.req_s2;
        d_next.valid = 1'b1;
        d_next.data = s_reg.data;
      end
    end
  end

  // receiver registers
  always_ff @(posedge dst_clk or negedge dst_rstn) begin
    if (!dst_rstn) begin
      d_reg <= '0;
    end else begin
      d_reg <= d_next;
    end
  end
endmodule // irp_xfer

// ### irp_read_port.sv
// i2c target that selects a 32-bit register and reads it back
`timescale 1ns/1ns
`include "irp_map.svh"

module irp_read_port #(
  parameter int NUM_PORTS = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] address_strap_inputs,
  output logic reg_rd_req,
  output logic [NUM_PORTS-1:0] reg_rd_sel,
  output logic [1:0] reg_rd_port,
  output logic [11:0] reg_rd_addr,
  output logic [3:0] reg_rd_be,
  input wire logic reg_rd_ack,
  input wire logic [31:0] reg_rd_data,
  output logic rd_busy
);
  // elaboration check: the port field is only two bits wide
  if (NUM_PORTS < 1 || NUM_PORTS > 4) begin : g_bad_ports
    $error("irp: 1 to 4 ports");
  end

  // -------------------------------------------------------------
  // reset release, one synchroniser per domain
  // -------------------------------------------------------------
  logic [1:0] rst_sync_reg; // core reset release chain
  logic [1:0] lrst_sync_reg; // link reset release chain
  logic rstn; // core domain reset
  logic lrstn; // link domain reset

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // same release on the link clock
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      lrst_sync_reg <= 2'h0;
    end else begin
      lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
    end
  end

  assign rstn = rst_sync_reg[1];
  assign lrstn = lrst_sync_reg[1];

  // -------------------------------------------------------------
  // crossings: request to core, register word back to link
  // -------------------------------------------------------------
  irp_pkg::irp_link_t l_reg;
  irp_pkg::irp_link_t l_next;
  irp_pkg::irp_core_t c_reg;
  irp_pkg::irp_core_t c_next;

  irp_xfer_if #(.W(`IRP_REQ_W)) req_x ();
  irp_xfer_if #(.W(32)) ret_x ();

  // link to core: {port, dword address, byte enables}
  irp_xfer #(.W(`IRP_REQ_W)) u_req_xfer (
    .src_clk(link_clk),
    .src_rstn(lrstn),
    .src_ce(l_reg.ce_s2),
    .dst_clk(clk),
    .dst_rstn(rstn),
    .dst_ce(ce),
    .x(req_x.xfer)
  );

  // core to link: the register word
  irp_xfer #(.W(32)) u_ret_xfer (
    .src_clk(clk),
    .src_rstn(rstn),
    .src_ce(ce),
    .dst_clk(link_clk),
    .dst_rstn(lrstn),
    .dst_ce(l_reg.ce_s2),
    .x(ret_x.xfer)
  );

  assign req_x.src_valid = l_reg.req_go;
  assign req_x.src_data = {l_reg.cmd[1][`IRP_PORT_HI_BIT],
                           l_reg.cmd[2][`IRP_PORT_LO_BIT],
                           l_reg.cmd[2][`IRP_AHI_MSB:0], l_reg.cmd[3],
                           l_reg.cmd[2][`IRP_BE_MSB:`IRP_BE_LSB]};

  // -------------------------------------------------------------
  // link domain: bus conditions seen on oversampled pins
  // -------------------------------------------------------------
  logic scl_rise; // clock edge where the master samples
  logic scl_fall; // clock edge where the target may change data
  logic bus_start; // data falls while clock is high
  logic bus_stop; // data rises while clock is high
  logic [6:0] own_addr; // target address after straps
  logic [7:0] next_byte; // byte the read pointer names

  assign scl_rise = l_reg.scl_s2 & ~l_reg.scl_s3;
  assign scl_fall = ~l_reg.scl_s2 & l_reg.scl_s3;
  assign bus_start = l_reg.scl_s2 & l_reg.scl_s3 &
                     ~l_reg.sda_s2 & l_reg.sda_s3;
  assign bus_stop = l_reg.scl_s2 & l_reg.scl_s3 &
                    l_reg.sda_s2 & ~l_reg.sda_s3;
  assign own_addr = `IRP_ADDR_BASE | {4'h0, l_reg.strap_s2};

  function automatic logic [7:0] pick_byte(input logic [31:0] w,
                                           input logic [1:0] sel);
    logic [7:0] b;
    unique case (sel)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
    endcase
    return b;
  endfunction

  // byte about to go out, for the first data drive of each byte
  assign next_byte = pick_byte(l_reg.hold, l_reg.byte_sel);

  // protocol engine; sda changes only after a clock fall
  always_comb begin
    l_next = l_reg;
    l_next.req_go = 1'b0;
    // enable crosses two flops and keeps running while frozen
    l_next.ce_s1 = ce;
    l_next.ce_s2 = l_reg.ce_s1;
    if (l_reg.ce_s2) begin
      l_next.scl_s1 = scl_in;
      l_next.scl_s2 = l_reg.scl_s1;
      l_next.scl_s3 = l_reg.scl_s2;
      l_next.sda_s1 = sda_in;
      l_next.sda_s2 = l_reg.sda_s1;
      l_next.sda_s3 = l_reg.sda_s2;
      l_next.strap_s1 = address_strap_inputs;
      l_next.strap_s2 = l_reg.strap_s1;
      if (ret_x.dst_valid) begin
        l_next.hold = ret_x.dst_data;
        l_next.pend = 1'b0;
      end
      if (bus_start) begin
        l_next.state = irp_pkg::LK_ADDR;
        l_next.bit_cnt = 4'h0;
        l_next.sda_oe = 1'b0;
        l_next.scl_oe = 1'b0;
      end else if (bus_stop) begin
        l_next.state = irp_pkg::LK_IDLE;
        l_next.sda_oe = 1'b0;
        l_next.scl_oe = 1'b0;
      end else begin
        unique case (l_reg.state)
          irp_pkg::LK_IDLE, irp_pkg::LK_WAIT: begin
            // nothing until the next start
          end
          irp_pkg::LK_ADDR: begin
            if (scl_rise) begin
              l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
              l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
            end else if (scl_fall && l_reg.bit_cnt == `IRP_BITS) begin
              if (l_reg.shift[7:1] == own_addr) begin
                l_next.rw = l_reg.shift[0];
                l_next.sda_oe = 1'b1;
                l_next.state = irp_pkg::LK_ADDR_ACK;
              end else begin
                l_next.state = irp_pkg::LK_WAIT;
              end
            end
          end
          irp_pkg::LK_ADDR_ACK: begin
            if (scl_fall) begin
              l_next.sda_oe = 1'b0;
              l_next.bit_cnt = 4'h0;
              if (!l_reg.rw) begin
                l_next.cmd_idx = 3'h0;
                l_next.state = irp_pkg::LK_CMD;
              end else begin
                l_next.byte_sel = 2'h0;
                l_next.state = irp_pkg::LK_STRETCH;
              end
            end
          end
          irp_pkg::LK_CMD: begin
            if (scl_rise) begin
              l_next.shift = {l_reg.shift[6:0], l_reg.sda_s2};
              l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
            end else if (scl_fall && l_reg.bit_cnt == `IRP_BITS) begin
              if (l_reg.cmd_idx < `IRP_NUM_CMD) begin
                l_next.cmd[l_reg.cmd_idx[1:0]] = l_reg.shift;
                l_next.sda_oe = 1'b1;
                l_next.state = irp_pkg::LK_CMD_ACK;
              end else begin
                l_next.state = irp_pkg::LK_WAIT;
              end
            end
          end
          irp_pkg::LK_CMD_ACK: begin
            if (scl_fall) begin
              l_next.sda_oe = 1'b0;
              l_next.bit_cnt = 4'h0;
              l_next.cmd_idx = l_reg.cmd_idx + 3'h1;
              l_next.state = irp_pkg::LK_CMD;
              if (l_reg.cmd_idx == `IRP_LAST_CMD &&
                  l_reg.cmd[0][`IRP_OP_MSB:0] == `IRP_OP_READ &&
                  !req_x.src_busy) begin
                l_next.req_go = 1'b1;
                l_next.pend = 1'b1;
              end
            end
          end
          irp_pkg::LK_STRETCH: begin
            // hold the clock low until the register word has arrived
            if (l_reg.pend) begin
              l_next.scl_oe = 1'b1;
            end else begin
              // data first; the clock is let go one cycle later
              l_next.bit_cnt = 4'h0;
              l_next.shift = pick_byte(l_reg.hold, l_reg.byte_sel);
              l_next.sda_oe = ~next_byte[7];
              l_next.state = irp_pkg::LK_RD_BYTE;
            end
          end
          irp_pkg::LK_RD_BYTE: begin
            // release a stretch only after the msb is on the line
            l_next.scl_oe = 1'b0;
            if (scl_fall) begin
              l_next.bit_cnt = l_reg.bit_cnt + 4'h1;
              if (l_reg.bit_cnt == `IRP_LAST_BIT) begin
                l_next.sda_oe = 1'b0;
                l_next.state = irp_pkg::LK_RD_ACK;
              end else begin
                l_next.shift = {l_reg.shift[6:0], 1'b0};
                l_next.sda_oe = ~l_reg.shift[6];
              end
            end
          end
          irp_pkg::LK_RD_ACK: begin
            if (scl_rise) begin
              if (l_reg.sda_s2) begin
                l_next.state = irp_pkg::LK_WAIT;
              end else begin
                l_next.byte_sel = l_reg.byte_sel + 2'h1;
                l_next.state = irp_pkg::LK_RD_NEXT;
              end
            end
          end
          irp_pkg::LK_RD_NEXT: begin
            if (scl_fall) begin
              l_next.bit_cnt = 4'h0;
              l_next.shift = pick_byte(l_reg.hold, l_reg.byte_sel);
              l_next.sda_oe = ~next_byte[7];
              l_next.state = irp_pkg::LK_RD_BYTE;
            end
          end
        endcase
      end
    end
  end

  // link registers
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      l_reg <= '{state: irp_pkg::LK_IDLE, scl_s1: 1'b1, scl_s2: 1'b1,
                 scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
                 sda_s3: 1'b1, hold: `IRP_BUF_RST, default: '0};
    end else begin
      l_reg <= l_next;
    end
  end

  // open drain: only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = l_reg.scl_oe;
  assign sda_oe = l_reg.sda_oe;

  // -------------------------------------------------------------
  // core domain: one register fetch per read command to a present port
  // -------------------------------------------------------------
  function automatic logic [NUM_PORTS-1:0] port_onehot(
      input logic [1:0] p);
    logic [NUM_PORTS-1:0] o;
    o = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (p == i[1:0]) o[i] = 1'b1;
    end
    return o;
  endfunction

  // fetch, wait for the answer, send it to the link side
  always_comb begin
    c_next = c_reg;
    c_next.req = 1'b0;
    c_next.ret_go = 1'b0;
    if (ce) begin
      unique case (c_reg.state)
        irp_pkg::CR_IDLE: begin
          if (req_x.dst_valid) begin
            if (port_onehot(req_x.dst_data[15:14]) != '0) begin
              // fields move only with a request and stand until the next
              {c_next.port, c_next.addr, c_next.be} = req_x.dst_data;
              c_next.req = 1'b1;
              c_next.state = irp_pkg::CR_WAIT_ACK;
            end else begin
              c_next.data = `IRP_BUF_RST;
              c_next.state = irp_pkg::CR_RETURN;
            end
          end
        end
        irp_pkg::CR_WAIT_ACK: begin
          if (reg_rd_ack) begin
            c_next.data = reg_rd_data;
            c_next.state = irp_pkg::CR_RETURN;
          end
        end
        irp_pkg::CR_RETURN: begin
          if (!ret_x.src_busy) begin
            c_next.ret_go = 1'b1;
            c_next.state = irp_pkg::CR_IDLE;
          end
        end
      endcase
    end
  end

  // core registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      c_reg <= '{state: irp_pkg::CR_IDLE, data: `IRP_BUF_RST,
                 default: '0};
    end else begin
      c_reg <= c_next;
    end
  end

  assign ret_x.src_valid = c_reg.ret_go;
  assign ret_x.src_data = c_reg.data;
  assign reg_rd_req = c_reg.req;
  assign reg_rd_port = c_reg.port;
  assign reg_rd_sel = port_onehot(c_reg.port);
  assign reg_rd_addr = {c_reg.addr, 2'h0};
  assign reg_rd_be = c_reg.be;
  assign rd_busy = (c_reg.state != irp_pkg::CR_IDLE);
endmodule // irp_read_port

// ### irp_read_port_properties.sv
// concurrent checks on the ports of the i2c register read port
`timescale 1ns/1ns
module irp_read_port_properties #(
  parameter int NUM_PORTS = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic reg_rd_req,
  input wire logic [NUM_PORTS-1:0] reg_rd_sel,
  input wire logic [1:0] reg_rd_port,
  input wire logic [11:0] reg_rd_addr,
  input wire logic [3:0] reg_rd_be,
  input wire logic reg_rd_ack,
  input wire logic rd_busy
);
  // ----------------------------------------
  // register side, core clock
  // ----------------------------------------
  // the register side answering an open fetch
  sequence s_ack;
    rd_busy && reg_rd_ack;
  endsequence
  property p_req_pulse;
    @(posedge clk) disable iff (!resetn) reg_rd_req |=> !reg_rd_req [*3];
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("fetch request longer than one cycle");
  property p_addr_low;
    @(posedge clk) disable iff (!resetn) reg_rd_req |-> reg_rd_addr[1:0] == 2'h0;
  endproperty
  a_addr_low: assert property (p_addr_low)
    else $error("fetch address not dword aligned");
  property p_port_sel;
    @(posedge clk) disable iff (!resetn) reg_rd_req |->
      reg_rd_port < NUM_PORTS && reg_rd_sel == NUM_PORTS'(1) << reg_rd_port;
  endproperty
  a_port_sel: assert property (p_port_sel)
    else $error("port select does not match routed port");
  property p_req_busy;
    @(posedge clk) disable iff (!resetn) reg_rd_req |-> rd_busy;
  endproperty
  a_req_busy: assert property (p_req_busy)
    else $error("fetch issued without busy");
  property p_hold;
    @(posedge clk) disable iff (!resetn)
      !reg_rd_req |-> $stable({reg_rd_port, reg_rd_addr, reg_rd_be});
  endproperty
  a_hold: assert property (p_hold)
    else $error("fetch fields moved between requests");
  property p_busy_end;
    @(posedge clk) disable iff (!resetn) s_ack |-> ##[1:3] !rd_busy;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy did not end after answer");
  // ----------------------------------------
  // bus side, link clock
  // ----------------------------------------
  // data may only move while the clock line is low
  property p_sda_chg;
    @(posedge link_clk) disable iff (!resetn) $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_chg: assert property (p_sda_chg)
    else $error("data line moved while clock high");
  property p_stretch;
    @(posedge link_clk) disable iff (!resetn) $rose(scl_oe) |-> !scl_in;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch began while clock high");
endmodule // irp_read_port_properties

// ### irp_i2c_master.sv
// bus master model that drives the i2c pins from tasks
`timescale 1ns/1ns
module irp_i2c_master (
  output logic scl_drv,
  output logic sda_drv,
  input wire logic scl,
  input wire logic sda
);
  // half bit time, far above the ten link cycles the target needs
  localparam int T = 150;
  // released lines idle high through the pull-up
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // raise clock, then wait out any stretch by the target (bounded)
  task automatic rise();
    int n;
    n = 0;
    scl_drv = 1'b1;
    while (scl !== 1'b1 && n < 5000) begin
      #6;
      n++;
    end
  endtask
  // data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #(T / 2);
    sda_drv = b;
    #(T / 2);
    rise();
    #(T / 2);
    r = sda;
    #(T / 2);
    scl_drv = 1'b0;
  endtask
  // data edge a to b while clock is high: start or stop
  task automatic cond(input logic a, input logic b);
    #(T / 2);
    sda_drv = a;
    #(T / 2);
    rise();
    #T;
    sda_drv = b;
    #T;
  endtask
  task automatic start();
    cond(1'b1, 1'b0);
    scl_drv = 1'b0;
  endtask
  task automatic stop();
    cond(1'b0, 1'b1);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic nak, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(nak, r);
  endtask
endmodule // irp_i2c_master

// ### irp_read_port_test.sv
// self-checking bench of the i2c register read port
`timescale 1ns/1ns
module irp_read_port_test;
  localparam int NUM_PORTS = 3;
  logic clk, link_clk, resetn, ce, reg_rd_ack, k_ack, m_scl, m_sda;
  logic scl_out, scl_oe, sda_out, sda_oe, reg_rd_req, rd_busy;
  logic [2:0] straps;
  logic [31:0] reg_rd_data, buf_exp;
  logic [NUM_PORTS-1:0] reg_rd_sel;
  logic [1:0] reg_rd_port, cap_port;
  logic [11:0] reg_rd_addr, cap_addr;
  logic [3:0] reg_rd_be, cap_be;
  int bad_count, samples_checked, req_n, seed;
  // wired-and bus with pull-up
  wire scl_w = m_scl & ~scl_oe;
  wire sda_w = m_sda & ~sda_oe;
  irp_read_port #(.NUM_PORTS(NUM_PORTS)) DUT (.clk, .resetn, .ce,
    .link_clk, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out,
    .sda_oe, .address_strap_inputs(straps), .reg_rd_req, .reg_rd_sel,
    .reg_rd_port, .reg_rd_addr, .reg_rd_be, .reg_rd_ack, .reg_rd_data,
    .rd_busy);
  irp_i2c_master u_mst (.scl_drv(m_scl), .sda_drv(m_sda), .scl(scl_w),
    .sda(sda_w));
  // register word; every byte has a clear msb so a stray drive shows
  function automatic logic [31:0] reg_word(input logic [1:0] p,
      input logic [11:0] a);
    return (p == 2'h3) ? 32'h0 :
      {8'h5a, 6'h00, p, 4'h0, a[11:8], 1'b0, a[7:2], 1'b0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // one full read: command packet, optional stop, data packet
  task automatic do_read(input logic [1:0] p, input logic [11:0] a,
      input logic [3:0] be, input logic [2:0] op, input bit joined,
      input int nb);
    logic [7:0] b;
    logic [7:0] cmd [4];
    int n0;
    cmd = '{{5'h00, op}, {7'h00, p[1]}, {p[0], 1'b0, be, a[11:10]}, a[9:2]};
    n0 = req_n;
    u_mst.start();
    u_mst.wbyte({4'h7, straps, 1'b0}, k_ack);
    chk(k_ack, 1'b1);
    foreach (cmd[i]) begin
      u_mst.wbyte(cmd[i], k_ack);
      chk(k_ack, 1'b1);
    end
    if (!joined) u_mst.stop();
    u_mst.start();
    u_mst.wbyte({4'h7, straps, 1'b1}, k_ack);
    chk(k_ack, 1'b1);
    if (op == 3'h4) buf_exp = reg_word(p, a);
    for (int i = 0; i < nb; i++) begin
      u_mst.rbyte(i == nb - 1, b);
      chk(b, buf_exp[8 * (3 - i % 4) +: 8]);
    end
    #100;
    chk(sda_oe, 1'b0);
    chk({scl_out, sda_out}, 2'h0);
    u_mst.stop();
    chk(req_n, n0 + ((op == 3'h4 && p != 2'h3) ? 1 : 0));
    if (req_n != n0) chk({cap_port, cap_be, cap_addr}, {p, be, a});
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // link clock at 6 ns, offset from the core clock
  initial begin
    link_clk = 1'b0;
    #2;
    forever #3 link_clk = ~link_clk;
  end
  // register side: random answer latency, garbage outside the answer
  initial begin
    forever begin
      @(posedge clk);
      if (reg_rd_req === 1'b1) begin
        req_n++;
        cap_port = reg_rd_port;
        cap_addr = reg_rd_addr;
        cap_be = reg_rd_be;
        // every other fetch answers late, so the target must stretch
        repeat ((req_n % 2 == 1) ? 90 : 1 + $urandom % 8) @(posedge clk);
        reg_rd_ack <= 1'b1;
        reg_rd_data <= reg_word(cap_port, cap_addr);
        @(posedge clk);
        reg_rd_ack <= 1'b0;
        reg_rd_data <= ~reg_word(cap_port, cap_addr);
      end
    end
  end
  // watchdog, well beyond the expected run
  initial begin
    #4_000_000;
    bad_count++;
    results();
  end
  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    reg_rd_ack = 1'b0;
    reg_rd_data = 32'h0;
    straps = 3'h0;
    bad_count = 0;
    samples_checked = 0;
    req_n = 0;
    buf_exp = 32'h0;
    seed = $urandom(26389);
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    do_read(2'h0, 12'h0b4, 4'hf, 3'h4, 1'b1, 4);
    $display("test walk done");
    for (int p = 0; p < 4; p++) do_read(2'(p), 12'hffc, 4'h5, 3'h4, 1'b0, 4);
    $display("test ports done");
    for (int op = 0; op < 8; op++) do_read(2'h1, 12'h010, 4'ha, 3'(op), 1'b1, 6);
    $display("test opcodes done");
    u_mst.start();
    u_mst.wbyte(8'h72, k_ack);
    chk(k_ack, 1'b0);
    u_mst.stop();
    $display("test wrong address done");
    repeat (6) begin
      @(posedge clk);
      straps <= 3'($urandom);
      repeat (4) @(posedge clk);
      do_read(2'($urandom % 3), {10'($urandom), 2'h0}, 4'($urandom), 3'h4,
        1'($urandom), 1 + $urandom % 9);
    end
    $display("test random done");
    results();
  end
endmodule // irp_read_port_test
bind irp_read_port irp_read_port_properties #(.NUM_PORTS(NUM_PORTS)) u_props (
  .clk, .resetn, .link_clk, .scl_in, .scl_oe, .sda_oe, .reg_rd_req,
  .reg_rd_sel, .reg_rd_port, .reg_rd_addr, .reg_rd_be, .reg_rd_ack, .rd_busy);
